// ==== core/coil_bank_consts.svh ====
// Offsets, field positions, reset values and counts of the status coil bank.
// Function
// - Zero-based bank of one-bit read-only coils.
// - Coil 0 set while measuring.
// - Coil 1 set while cooler runs.
// - Coil 2 set in standby, unit active.
// - Coil 3 summary: any alarm active.
// - Coil 4 summary: any warning active.
// - Coil 5 set while calibrating.
// - Coil 6 ack pending, network ack source.
// - Coils 7,8 low/high system pressure alarms.
// - Coils 9,10 system/probe high temperature alarms.
// - Coil 11 calibration acknowledge timeout alarm.
// - Coil 12 light source intensity alarm.
// - Coils 13-17 internal hardware fault alarms.
// - Coils 18-22 card, UV, memory, panel, spectrometer.
// - Coils 23-29 system and lamp warnings.
// - Coils 30-34 gas high-level warnings.
// - Coils 35-40 gas out-of-bounds warnings.
// - Coils 41-44 gas-in-lamp warnings.
// - Coil 45 missing positioning signal warning.
// - Coil 46 invalid gas configuration.
// - Coils 47,48 lamp worn, lamp wearing.
// - Coil 49 time of day not set.
// - Bad requests answer with exception code.
`ifndef COIL_BANK_CONSTS_SVH
`define COIL_BANK_CONSTS_SVH

`define COIL_COUNT          50
`define ALARM_SRC_COUNT     16
`define WARN_SRC_COUNT      23
`define STATE_MEASURING     4'h3
`define STATE_CALIBRATING   4'h2
`define STATE_STANDBY       4'h0
`define STATE_RESET         4'h0
`define REG_COILS_LO        32'h0000_0000
`define REG_COILS_HI        32'h0000_0004
`define REG_REQUEST         32'h0000_0008
`define REG_RESPONSE        32'h0000_000c
`define REG_CONTROL         32'h0000_0010
`define CTRL_ACK_NET_BIT    0
`define FN_READ_COILS       8'h01
`define EXC_FLAG            8'h80
`define EXC_ILLEGAL_FN      8'h01
`define EXC_ILLEGAL_ADDR    8'h02
`define EXC_INVALID_PARAM   8'h03
`define RESP_REPLY_BIT      31
`define RESP_EXC_BIT        30

`endif

// ==== core/coil_bank_pkg.sv ====
// Types of the status coil bank.
package coil_bank_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ACK
  } bus_phase_t;

  typedef struct packed {
    logic [1:0]  rst_sync;
    bus_phase_t  phase;
    logic [31:0] dat;
    logic        ack_net;
    logic [15:0] req_addr;
    logic [15:0] req_qty;
    logic [7:0]  req_fn;
    logic [7:0]  rsp_fn;
    logic [7:0]  rsp_code;
    logic        rsp_exc;
    logic        rsp_valid;
    logic [63:0] rsp_bits;
    logic [3:0]  state_seen;
    logic [3:0]  state_held;
  } bank_state_t;
endpackage : coil_bank_pkg

// ==== core/sync_2ff.sv ====
// Two-flop synchroniser for one bundle of asynchronous levels.
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= '0;
      dout    <= '0;
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end
endmodule : sync_2ff

// ==== core/alarm_warning_coil_bank.sv ====
// Status coil bank: live sensor conditions as coils, read over Wishbone.
`timescale 1ns/1ps
`include "coil_bank_consts.svh"
module alarm_warning_coil_bank (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // Wishbone classic slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Sensor conditions, asynchronous to sys_clk.
  input  wire logic [3:0]  op_state,
  input  wire logic        cooler_on,
  input  wire logic        probe_unit_active,
  input  wire logic        cal_ack_wait,
  input  wire logic [1:0]  pressure_alarm,
  input  wire logic [1:0]  temp_alarm,
  input  wire logic        cal_ack_timeout_alarm,
  input  wire logic        light_intensity_alarm,
  input  wire logic [4:0]  hw_fault_alarm,
  input  wire logic [4:0]  misc_alarm,
  input  wire logic [6:0]  sys_warning,
  input  wire logic [4:0]  gas_high_warning,
  input  wire logic [5:0]  gas_bounds_warning,
  input  wire logic [3:0]  gas_in_lamp_warning,
  input  wire logic        no_gps_warning,
  input  wire logic        gas_config_invalid,
  input  wire logic        lamp_worn_out,
  input  wire logic        lamp_wearing,
  input  wire logic        time_not_set
);
  localparam int SRC_W = 4 + 1 + 1 + 1 + 2 + 2 + 1 + 1 + 5 + 5 + 7 + 5 + 6 + 4 + 1 + 1 + 1 + 1 + 1;

  coil_bank_pkg::bank_state_t st_ff;
  coil_bank_pkg::bank_state_t nxt_st;
  logic                       rst_int_b;
  logic [SRC_W-1:0]           src_raw;
  logic [SRC_W-1:0]           src_sync;
  logic [63:0]                coils;
  logic [3:0]                 s_state;
  logic [15:0]                alarms;
  logic [22:0]                warns;

  assign rst_int_b = st_ff.rst_sync[1];

  assign src_raw = {op_state, cooler_on, probe_unit_active, cal_ack_wait, pressure_alarm,
                    temp_alarm, cal_ack_timeout_alarm, light_intensity_alarm, hw_fault_alarm,
                    misc_alarm, sys_warning, gas_high_warning, gas_bounds_warning,
                    gas_in_lamp_warning, no_gps_warning, gas_config_invalid, lamp_worn_out,
                    lamp_wearing, time_not_set};

  // Every condition passes two flops before the coil logic sees it.
  sync_2ff #(
    .WIDTH (SRC_W)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_int_b),
    .din     (src_raw),
    .dout    (src_sync)
  );

  // Coils are decoded combinationally from the synchronised sources (coils 0, 2 and 5
  // from the held state code), so no read can latch or clear them.
  always_comb begin
    s_state = st_ff.state_held;
    alarms  = {src_sync[42:41], src_sync[40:39], src_sync[38], src_sync[37],
               src_sync[36:32], src_sync[31:27]};
    warns   = {src_sync[26:20], src_sync[19:15], src_sync[14:9], src_sync[8:4]};
    coils   = '0;
    coils[0]     = (s_state == `STATE_MEASURING);
    coils[1]     = src_sync[45];
    coils[2]     = src_sync[44] && (s_state == `STATE_STANDBY);
    coils[3]     = (|alarms) | src_sync[2];
    coils[4]     = (|warns) | src_sync[1];
    coils[5]     = (s_state == `STATE_CALIBRATING);
    coils[6]     = src_sync[43] && st_ff.ack_net;
    coils[8:7]   = src_sync[42:41];
    coils[10:9]  = src_sync[40:39];
    coils[11]    = src_sync[38];
    coils[12]    = src_sync[37];
    coils[17:13] = src_sync[36:32];
    coils[22:18] = src_sync[31:27];
    coils[29:23] = src_sync[26:20];
    coils[34:30] = src_sync[19:15];
    coils[40:35] = src_sync[14:9];
    coils[44:41] = src_sync[8:5];
    coils[45]    = src_sync[4];
    coils[46]    = src_sync[3];
    coils[47]    = src_sync[2];
    coils[48]    = src_sync[1];
    coils[49]    = src_sync[0];
  end

  logic [31:0] wmask;
  logic [31:0] lo_in;
  logic [15:0] first;
  logic [16:0] last;
  logic [63:0] shifted;

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.rst_sync = {st_ff.rst_sync[0], 1'b1};
    // The state code is a word whose bits may settle on different cycles, so
    // it is taken only once two synchronised samples agree; costs two cycles.
    nxt_st.state_seen = src_sync[SRC_W-1 -: 4];
    if (src_sync[SRC_W-1 -: 4] == st_ff.state_seen) begin
      nxt_st.state_held = st_ff.state_seen;
    end
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    lo_in = 32'h0000_0000;
    first = st_ff.req_addr;
    last  = {1'b0, st_ff.req_addr} + {1'b0, st_ff.req_qty};
    shifted = coils >> first[5:0];
    unique case (st_ff.phase)
      coil_bank_pkg::BUS_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          nxt_st.phase = coil_bank_pkg::BUS_ACK;
          nxt_st.dat   = 32'h0000_0000;
          if (wb_we_i) begin
            unique case (wb_adr_i)
              `REG_REQUEST: begin
                lo_in = (wb_dat_i & wmask) | ({st_ff.req_qty, st_ff.req_addr} & ~wmask);
                nxt_st.req_addr = lo_in[15:0];
                nxt_st.req_qty  = lo_in[31:16];
              end
              `REG_CONTROL: begin
                if (wb_sel_i[0]) begin
                  nxt_st.ack_net = wb_dat_i[`CTRL_ACK_NET_BIT];
                end
              end
              `REG_RESPONSE: begin
                // Writing the function byte launches a request.
                if (wb_sel_i[0]) begin
                  nxt_st.req_fn    = wb_dat_i[7:0];
                  nxt_st.rsp_valid = 1'b1;
                  nxt_st.rsp_fn    = wb_dat_i[7:0];
                  nxt_st.rsp_exc   = 1'b0;
                  nxt_st.rsp_code  = 8'h00;
                  nxt_st.rsp_bits  = 64'h0;
                  if (wb_dat_i[7:0] != `FN_READ_COILS) begin
                    nxt_st.rsp_exc  = 1'b1;
                    nxt_st.rsp_fn   = wb_dat_i[7:0] | `EXC_FLAG;
                    nxt_st.rsp_code = `EXC_ILLEGAL_FN;
                  end else if (st_ff.req_qty == 16'h0000 || last > 17'(`COIL_COUNT)) begin
                    nxt_st.rsp_exc  = 1'b1;
                    nxt_st.rsp_fn   = `FN_READ_COILS | `EXC_FLAG;
                    nxt_st.rsp_code = `EXC_INVALID_PARAM;
                  end else begin
                    // Coils beyond the requested count read as zero.
                    for (int i = 0; i < 64; i++) begin
                      nxt_st.rsp_bits[i] = (i < int'(st_ff.req_qty)) ? shifted[i] : 1'b0;
                    end
                  end
                end
              end
              default: ;
            endcase
          end else begin
            unique case (wb_adr_i)
              `REG_COILS_LO: nxt_st.dat = coils[31:0];
              `REG_COILS_HI: nxt_st.dat = coils[63:32];
              `REG_REQUEST:  nxt_st.dat = {st_ff.req_qty, st_ff.req_addr};
              `REG_RESPONSE: nxt_st.dat = {st_ff.rsp_valid, st_ff.rsp_exc, 6'h00,
                                           st_ff.rsp_bits[7:0], st_ff.rsp_code, st_ff.rsp_fn};
              `REG_CONTROL:  nxt_st.dat = {31'h0, st_ff.ack_net};
              default:       nxt_st.dat = 32'h0000_0000;
            endcase
          end
        end
      end
      coil_bank_pkg::BUS_ACK: begin
        nxt_st.phase = coil_bank_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else if (!st_ff.rst_sync[1]) begin
      st_ff          <= '0;
      st_ff.rst_sync <= nxt_st.rst_sync;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_ack_o = (st_ff.phase == coil_bank_pkg::BUS_ACK);
  assign wb_dat_o = st_ff.dat;
endmodule : alarm_warning_coil_bank

// ==== tb/coil_bank_checker.sv ====
// Bus timing and coil value checks for the status coil bank.
`timescale 1ns/1ps
module coil_bank_checker (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [3:0]  op_state,
  input wire logic [1:0]  pressure_alarm,
  input wire logic        time_not_set
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Six quiet cycles cover the two-flop lag of the condition inputs.
  sequence rd_at(logic [31:0] a);
    wb_ack_o && !wb_we_i && wb_adr_i == a;
  endsequence
  chk_ack_latency: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_no_stray: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_unmapped_zero: assert property (rd_at(32'h14) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_hi_upper: assert property (rd_at(32'h4) |-> wb_dat_o[31:18] == 14'h0)
    else $error("coil bits above 49 not zero");
  chk_coil_measuring: assert property ($stable(op_state)[*6] ##0 rd_at(32'h0)
    |-> wb_dat_o[0] == (op_state == 4'h3)) else $error("coil 0 wrong");
  chk_coil_pressure: assert property ($stable(pressure_alarm)[*6] ##0 rd_at(32'h0)
    |-> wb_dat_o[8:7] == pressure_alarm) else $error("coils 7 and 8 wrong");
  chk_coil_time: assert property ($stable(time_not_set)[*6] ##0 rd_at(32'h4)
    |-> wb_dat_o[17] == time_not_set) else $error("coil 49 wrong");
endmodule : coil_bank_checker

bind alarm_warning_coil_bank coil_bank_checker chk (.*);

// ==== tb/sensor_source.sv ====
// Sensor side model: drives condition levels and predicts both coil words.
`timescale 1ns/1ps
module sensor_source (
  input  wire logic [49:0] cond,
  input  wire logic        ack_net,
  output logic      [3:0]  op_state,
  output logic             cooler_on,
  output logic             probe_unit_active,
  output logic             cal_ack_wait,
  output logic      [1:0]  pressure_alarm,
  output logic      [1:0]  temp_alarm,
  output logic             cal_ack_timeout_alarm,
  output logic             light_intensity_alarm,
  output logic      [4:0]  hw_fault_alarm,
  output logic      [4:0]  misc_alarm,
  output logic      [6:0]  sys_warning,
  output logic      [4:0]  gas_high_warning,
  output logic      [5:0]  gas_bounds_warning,
  output logic      [3:0]  gas_in_lamp_warning,
  output logic             no_gps_warning,
  output logic             gas_config_invalid,
  output logic             lamp_worn_out,
  output logic             lamp_wearing,
  output logic             time_not_set,
  output logic      [31:0] exp_lo,
  output logic      [31:0] exp_hi
);
  // Bits 7 and up of cond line up with the coil numbers.
  assign {time_not_set, lamp_wearing, lamp_worn_out, gas_config_invalid, no_gps_warning,
          gas_in_lamp_warning, gas_bounds_warning, gas_high_warning, sys_warning, misc_alarm,
          hw_fault_alarm, light_intensity_alarm, cal_ack_timeout_alarm, temp_alarm,
          pressure_alarm, cal_ack_wait, probe_unit_active, cooler_on, op_state} = cond;
  assign exp_lo = {cond[31:7], cal_ack_wait & ack_net, op_state == 4'h2,
                   (|cond[45:23]) | cond[48], (|cond[22:7]) | cond[47],
                   probe_unit_active & (op_state == 4'h0), cooler_on, op_state == 4'h3};
  assign exp_hi = {14'h0, cond[49:32]};
endmodule : sensor_source

// ==== tb/alarm_warning_coil_bank_tb.sv ====
// Self-checking bench for the status coil bank.
`timescale 1ns/1ps
module alarm_warning_coil_bank_tb;
  logic        sys_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ack_net;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, exp_lo, exp_hi, rd;
  logic [3:0]  wb_sel_i, op_state, gas_in_lamp_warning;
  logic [1:0]  pressure_alarm, temp_alarm;
  logic [4:0]  hw_fault_alarm, misc_alarm, gas_high_warning;
  logic [6:0]  sys_warning;
  logic [5:0]  gas_bounds_warning;
  logic [49:0] cond;
  logic        cooler_on, probe_unit_active, cal_ack_wait, cal_ack_timeout_alarm;
  logic        light_intensity_alarm, no_gps_warning, gas_config_invalid;
  logic        lamp_worn_out, lamp_wearing, time_not_set;
  int          mismatches, cmp_count;
  alarm_warning_coil_bank dut (.*);
  sensor_source src (.*);
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // The request holds until ack is sampled at a rising edge, then drops for a cycle.
  task automatic bus(input logic we, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (n == 20) begin
      mismatches++;
      summarize();
    end
  endtask : bus
  task automatic expect_coils(input logic [49:0] c);
    cond <= c;
    repeat (6) @(posedge sys_clk);
    bus(1'b0, 32'h0, 32'h0);
    check("coils_lo", exp_lo, rd);
    bus(1'b0, 32'h4, 32'h0);
    check("coils_hi", exp_hi, rd);
  endtask : expect_coils
  task automatic walk_sources();
    for (int i = 0; i < 50; i++) expect_coils(50'h1 << i);
  endtask : walk_sources
  task automatic state_coils();
    expect_coils(50'h3);
    expect_coils(50'h20);
    expect_coils(50'h23);
    expect_coils(50'h40);
    bus(1'b1, 32'h10, 32'h1);
    bus(1'b0, 32'h10, 32'h0);
    check("control", 32'h1, rd);
    ack_net <= 1'b1;
    expect_coils(50'h40);
    expect_coils(50'h0);
  endtask : state_coils
  // A reset in mid-run must clear the acknowledge source back to local.
  task automatic reset_mid();
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    ack_net <= 1'b0;
    repeat (3) @(posedge sys_clk);
    bus(1'b0, 32'h10, 32'h0);
    check("control_reset", 32'h0, rd);
    expect_coils(50'h40);
  endtask : reset_mid
  task automatic unmapped_access();
    bus(1'b1, 32'h14, 32'hffff_ffff);
    bus(1'b0, 32'h14, 32'h0);
    check("unmapped", 32'h0, rd);
    bus(1'b1, 32'h8, 32'hffff_ffff);
    wb_sel_i <= 4'h3;
    bus(1'b1, 32'h8, 32'h0);
    wb_sel_i <= 4'hf;
    bus(1'b0, 32'h8, 32'h0);
    check("request_sel", 32'hffff_0000, rd);
    expect_coils(50'h2_0000_0000_0003);
  endtask : unmapped_access
  task automatic request(input logic [31:0] q, input logic [7:0] fn, input logic [31:0] exp,
                         input logic [31:0] mask);
    int n;
    bus(1'b1, 32'h8, q);
    bus(1'b1, 32'hc, {24'h0, fn});
    rd = 32'h0;
    for (n = 0; n < 20 && rd[31] !== 1'b1; n++) bus(1'b0, 32'hc, 32'h0);
    if (n == 20) begin
      mismatches++;
      summarize();
    end
    check("response", exp, rd & mask);
  endtask : request
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, ack_net} = 5'h0;
    {wb_adr_i, wb_dat_i} = 64'h0;
    wb_sel_i = 4'hf;
    cond = 50'h0;
    mismatches = 0;
    cmp_count = 0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    expect_coils(50'h0);
    walk_sources();
    state_coils();
    reset_mid();
    unmapped_access();
    request(32'h0008_0000, 8'h01, {2'b10, 6'h0, exp_lo[7:0], 16'h0001}, 32'hc0ff_ffff);
    request(32'h0008_0000, 8'h05, 32'hc000_0185, 32'hc000_ffff);
    request(32'h0000_0000, 8'h01, 32'hc000_0381, 32'hc000_ffff);
    request(32'h0002_0031, 8'h01, 32'hc000_0381, 32'hc000_ffff);
    request(32'h0001_0031, 8'h01, 32'h8001_0001, 32'hc0ff_ffff);
    summarize();
  end
endmodule : alarm_warning_coil_bank_tb
